// [core/rivu_pkg.sv]
package rivu_pkg;

  // source count and vector geometry
  localparam int          NUM_IRQ      = 23;
  localparam int          PC_W         = 16;
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam logic [15:0] VECTOR_STEP  = 16'h0002;
  localparam logic [15:0] PC_RESET     = 16'h0000;

  // request bit positions, lowest index wins
  localparam int IRQ_EXT0       = 0;
  localparam int IRQ_EXT7       = 7;
  localparam int IRQ_T2_MATCH   = 8;
  localparam int IRQ_T2_OVF     = 9;
  localparam int IRQ_T1_CAPTURE = 10;
  localparam int IRQ_T1_MATCH_A = 11;
  localparam int IRQ_T1_MATCH_B = 12;
  localparam int IRQ_T1_OVF     = 13;
  localparam int IRQ_T0_MATCH   = 14;
  localparam int IRQ_T0_OVF     = 15;
  localparam int IRQ_SYNC_DONE  = 16;
  localparam int IRQ_RX_DONE    = 17;
  localparam int IRQ_TX_EMPTY   = 18;
  localparam int IRQ_TX_DONE    = 19;
  localparam int IRQ_CONV_DONE  = 20;
  localparam int IRQ_NVM_READY  = 21;
  localparam int IRQ_CMP_EVENT  = 22;

  // entry sequence states
  typedef enum logic [1:0] {
    RIVU_RUN,
    RIVU_PUSH_LO,
    RIVU_PUSH_HI,
    RIVU_LOAD
  } rivu_state_t;

  // request bundle from peripherals
  typedef struct packed {
    logic [NUM_IRQ-1:0] pending;
    logic [NUM_IRQ-1:0] enable;
  } rivu_req_t;

  // stack write toward data memory
  typedef struct packed {
    logic            push;
    logic [7:0]      data;
  } rivu_push_t;

  // whole block state
  typedef struct packed {
    rivu_state_t     state;
    logic [PC_W-1:0] ret_addr;
    logic [PC_W-1:0] vector;
    logic [4:0]      src;
    logic            ack;
    logic            load;
    logic [PC_W-1:0] load_addr;
    rivu_push_t      stack;
  } rivu_regs_t;

endpackage

// [core/rivu_top.sv]
// Behaviour
// - twenty-three interrupt sources besides reset, each with its own vector.
// - reset and every interrupt have distinct program memory entry addresses.
// - a request is taken only if its enable and the global enable are set.
// - vectors sit at the lowest program addresses and cannot be moved.
// - among several enabled pending requests the lowest vector address wins.
// - reset from pin, power-on or watchdog has top priority, vector zero.
// - external requests 0..7 vector from 0x0002 to 0x0010, two words apart.
// - timer vectors 0x0012..0x0020 in timer2, timer1, timer0 order.
// - serial vectors 0x0022..0x0028: sync done, receive, tx empty, tx done.
// - converter, nonvolatile memory ready, comparator at 0x002A..0x002E.
// - status register is neither saved on entry nor restored on return.
`timescale 1ns/10ps
module rivu_top
  import rivu_pkg::*;
(
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // reset causes, already in the core clock domain
  input  wire logic                 pin_reset,
  input  wire logic                 power_on_reset,
  input  wire logic                 watchdog_reset,
  // peripheral requests and their enables
  input  wire rivu_pkg::rivu_req_t  req,
  // status register global enable bit
  input  wire logic                 global_int_enable,
  // fetch logic interface
  input  wire logic                 insn_boundary,
  input  wire logic [15:0]          pc_now,
  // program counter load
  output logic                      pc_load,
  output logic [15:0]               pc_load_addr,
  // stack push of return address, low byte first
  output rivu_pkg::rivu_push_t      stack_out,
  // acknowledge to the winning source, one cycle
  output logic                      irq_ack,
  output logic [4:0]                irq_ack_src,
  // busy while the entry sequence runs
  output logic                      entry_busy,
  // winning vector shown while idle
  output logic [15:0]               vector_addr
);
  import rivu_pkg::*;

  rivu_regs_t r;
  rivu_regs_t next_r;
  logic [NUM_IRQ-1:0] taken;
  logic               any_taken;
  logic [4:0]         win;
  logic               any_reset;

  // fixed vector per source, hardwired, no relocation register
  function automatic logic [15:0] vec_of(input logic [4:0] idx);
    vec_of = 16'(RESET_VECTOR + VECTOR_STEP * (16'(idx) + 16'h0001));
  endfunction

  // gating by individual and global enable
  assign taken     = req.pending & req.enable & {NUM_IRQ{global_int_enable}};
  assign any_taken = |taken;
  assign any_reset = pin_reset | power_on_reset | watchdog_reset;

  // lowest index wins, matching lowest vector address
  always_comb begin
    win = 5'h00;
    for (int i = NUM_IRQ - 1; i >= 0; i--) begin
      if (taken[i]) begin
        win = 5'(i);
      end
    end
  end

  // entry sequence; status flags untouched, software saves them
  always_comb begin
    next_r            = r;
    next_r.ack        = 1'b0;
    next_r.load       = 1'b0;
    next_r.stack.push = 1'b0;
    unique case (r.state)
      RIVU_RUN: begin
        next_r.vector = vec_of(win);
        // no entry while a load is in flight: pc_now is still the old value then
        if (insn_boundary && any_taken && !r.load) begin
          next_r.ret_addr   = pc_now;
          next_r.src        = win;
          next_r.vector     = vec_of(win);
          next_r.ack        = 1'b1;
          next_r.stack.push = 1'b1;
          next_r.stack.data = pc_now[7:0];
          next_r.state      = RIVU_PUSH_HI;
        end
      end
      RIVU_PUSH_LO: begin
        next_r.state = RIVU_RUN;
      end
      RIVU_PUSH_HI: begin
        next_r.stack.push = 1'b1;
        next_r.stack.data = r.ret_addr[15:8];
        next_r.state      = RIVU_LOAD;
      end
      RIVU_LOAD: begin
        next_r.load      = 1'b1;
        next_r.load_addr = r.vector;
        next_r.state     = RIVU_RUN;
      end
    endcase
    // reset outranks everything and restarts at vector zero
    if (any_reset) begin
      next_r.state      = RIVU_RUN;
      next_r.ack        = 1'b0;
      next_r.stack.push = 1'b0;
      next_r.load       = 1'b1;
      next_r.load_addr  = RESET_VECTOR;
    end
  end

  // single state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r <= '{state: RIVU_RUN, ret_addr: PC_RESET, vector: RESET_VECTOR, src: 5'h00,
             ack: 1'b0, load: 1'b0, load_addr: RESET_VECTOR,
             stack: '{push: 1'b0, data: 8'h00}};
    end else begin
      r <= next_r;
    end
  end

  // outputs straight from the state register
  assign pc_load      = r.load;
  assign pc_load_addr = r.load_addr;
  assign stack_out    = r.stack;
  assign irq_ack      = r.ack;
  assign irq_ack_src  = r.src;
  assign entry_busy   = (r.state != RIVU_RUN) || r.load; // load cycle still busy
  assign vector_addr  = r.vector;

endmodule

// [dv/rivu_cpu.sv]
`timescale 1ns/10ps
module rivu_cpu
(
  // fetch side
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        stall,
  input  wire logic        pc_load,
  input  wire logic [15:0] pc_load_addr,
  output logic             insn_boundary,
  output logic [15:0]      pc_now
);
  // pc steps each cycle so every push carries a fresh address
  always_ff @(posedge clk or posedge rst) begin
    if (rst) pc_now <= 16'h0100;
    else if (pc_load) pc_now <= pc_load_addr;
    else pc_now <= pc_now + 16'h0001;
  end
  // a slow fetch holds the boundary off
  assign insn_boundary = !stall;
endmodule

// [dv/rivu_top_asserts.sv]
`timescale 1ns/10ps
module rivu_chk
  import rivu_pkg::*;
(
  // watched ports
  input wire logic                clk,
  input wire logic                rst,
  input wire logic                pin_reset,
  input wire logic                power_on_reset,
  input wire logic                watchdog_reset,
  input wire rivu_pkg::rivu_req_t req,
  input wire logic                global_int_enable,
  input wire logic                insn_boundary,
  input wire logic [15:0]         pc_now,
  input wire logic                pc_load,
  input wire logic [15:0]         pc_load_addr,
  input wire rivu_pkg::rivu_push_t stack_out,
  input wire logic                irq_ack,
  input wire logic [4:0]          irq_ack_src,
  input wire logic                entry_busy,
  input wire logic [15:0]         vector_addr
);
  // reset causes abort entries, so they mask the entry checks
  wire rs = pin_reset | power_on_reset | watchdog_reset;
  wire tk = insn_boundary & !entry_busy & global_int_enable & (|(req.pending & req.enable));
  // lowest set index is the expected winner
  function automatic logic [4:0] low(logic [22:0] v);
    low = 5'h00;
    for (int i = 22; i >= 0; i--) if (v[i]) low = 5'(i);
  endfunction
  default clocking @(posedge clk); endclocking
  default disable iff (rst || rs);
  AST_ACK_LO: assert property (
    tk |=> irq_ack && stack_out.push && stack_out.data == $past(pc_now[7:0]))
    else $error("ack or low byte push wrong");
  AST_PUSH_HI: assert property (
    tk |=> ##1 stack_out.push && stack_out.data == $past(pc_now[15:8], 2))
    else $error("high byte push wrong");
  AST_WIN: assert property (
    tk |=> irq_ack_src == low($past(req.pending & req.enable)))
    else $error("wrong winner");
  AST_VEC: assert property (
    irq_ack |-> ##2 pc_load && pc_load_addr == VECTOR_STEP * (16'(irq_ack_src) + 16'h0001))
    else $error("wrong vector load");
  AST_GATE: assert property (
    irq_ack |-> $past(global_int_enable && insn_boundary && !entry_busy
                      && (|(req.pending & req.enable))))
    else $error("ack without enable");
  AST_RST: assert property (disable iff (rst) rs |=> pc_load && pc_load_addr == RESET_VECTOR)
    else $error("reset cause not to zero");
  AST_BUSY: assert property (irq_ack |-> entry_busy [*3] ##1 !entry_busy)
    else $error("busy span wrong");
  AST_NOSAVE: assert property (irq_ack |=> stack_out.push ##1 !stack_out.push)
    else $error("extra push on entry");
  AST_IDLE_VEC: assert property (!entry_busy |=> vector_addr == VECTOR_STEP *
    (16'(low($past(req.pending & req.enable & {23{global_int_enable}}))) + 16'h0001))
    else $error("idle vector wrong");
endmodule
bind rivu_top rivu_chk u_chk (.clk, .rst, .pin_reset, .power_on_reset, .watchdog_reset, .req,
  .global_int_enable, .insn_boundary, .pc_now, .pc_load, .pc_load_addr, .stack_out, .irq_ack,
  .irq_ack_src, .entry_busy, .vector_addr);

// [dv/rivu_top_test.sv]
`timescale 1ns/10ps
module rivu_top_test;
  import rivu_pkg::*;
  logic clk, rst, pin_reset, power_on_reset, watchdog_reset, global_int_enable, stall;
  logic insn_boundary, pc_load, irq_ack, entry_busy;
  logic [15:0] pc_now, pc_load_addr, a, vector_addr;
  logic [4:0] irq_ack_src, s;
  rivu_req_t req;
  rivu_push_t stack_out;
  int n_mismatch, n_checks;
  // 200 MHz core clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  rivu_top u_dut (.clk, .rst, .pin_reset, .power_on_reset, .watchdog_reset, .req,
    .global_int_enable, .insn_boundary, .pc_now, .pc_load, .pc_load_addr, .stack_out,
    .irq_ack, .irq_ack_src, .entry_busy, .vector_addr);
  rivu_cpu u_cpu (.clk, .rst, .stall, .pc_load, .pc_load_addr, .insn_boundary, .pc_now);
  task automatic chk(string n, logic [16:0] seen, logic [16:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s exp %h seen %h", n, exp, seen);
    end
  endtask
  task automatic tick(int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // raise a request, drop it once acknowledged, keep winner and vector
  task automatic take(logic [22:0] p, logic [22:0] e);
    req = '{pending: p, enable: e};
    for (int i = 0; i < 20 && irq_ack !== 1'b1; i++) tick(1);
    s = irq_ack_src;
    req.pending = 23'h0;
    for (int i = 0; i < 8 && pc_load !== 1'b1; i++) tick(1);
    a = pc_load_addr;
    tick(2);
  endtask
  task automatic t_causes;
    for (int k = 0; k < 3; k++) begin
      {pin_reset, power_on_reset, watchdog_reset} = 3'h1 << k;
      tick(1);
      chk("reset load", {pc_load, pc_load_addr}, {1'b1, RESET_VECTOR});
    end
    {pin_reset, power_on_reset, watchdog_reset} = 3'h0;
    tick(1);
  endtask
  task automatic t_sources;
    for (int i = 0; i < NUM_IRQ; i++) begin
      take(23'h1 << i, 23'h7FFFFF);
      chk("src", 17'(s), 17'(i));
      chk("vector", {1'b0, a}, {1'b0, VECTOR_STEP * 16'(i + 1)});
    end
  endtask
  task automatic t_prio;
    take(23'h7FFFFF, 23'h7FFFF0);
    chk("prio", 17'(s), 17'h4);
  endtask
  // global enable off, then fetch stalled: nothing may start
  task automatic t_gate;
    for (int k = 0; k < 4; k += 3) begin
      {stall, global_int_enable} = 2'(k);
      req = '{pending: 23'h7FFFFF, enable: 23'h7FFFF0};
      repeat (8) begin
        tick(1);
        chk("idle", 17'(entry_busy), 17'h0);
      end
    end
    chk("idle vector", {1'b0, vector_addr}, {1'b0, VECTOR_STEP * 16'h0005});
    {stall, global_int_enable} = 2'h1;
    take(23'h7FFFFF, 23'h7FFFFF);
    chk("after gate", 17'(s), 17'h0);
  endtask
  task automatic close_out;
    if (n_mismatch == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    #20000;
    n_mismatch++;
    close_out;
  end
  initial begin
    {rst, pin_reset, power_on_reset, watchdog_reset, stall} = 5'h10;
    global_int_enable = 1'b1;
    req = 46'h0;
    tick(10);
    rst = 1'b0;
    t_causes;
    t_sources;
    t_prio;
    t_gate;
    close_out;
  end
endmodule
